// ===== output_slew_range_control.sv
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "slew_range_regs.svh"
// Behaviour
// - rate code picks update frequency from 258065 Hz down to 3300 Hz
// - with slew enabled output moves in steps, never jumps
// - one step per update period of the selected size, the last step clamped at the target
// - clear input with slew enabled ramps output to zero-scale
// - status bit 1 shows slew still active
// - update frequency the same for every range
// - range field selects the seven single-output spans
// - range code 100 in a control write is ignored, old range kept, other fields written
// - range change clears data to the clear level under new range
// - overrange bit widens voltage spans by ten percent
// - dual mode: range drives voltage only, 1xx disables voltage
// - dual mode current span field: off, 4-20, 0-20, 0-24 mA
// - modem coupling follows range code 101 (4-20 mA) only, in dual mode too, whatever the current span field
// - control bit4 enable, bits 7:5 step, bits 11:8 rate
// - step codes give 1 to 128 LSB in powers of two
// - data read during slew returns the stepped value
module output_slew_range_control
    import slew_range_pkg::*;
#(
    parameter int CLK_HZ = `SYS_CLK_HZ
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    input  wire logic        clear_input,
    input  wire logic        clear_level_select,
    output logic      [15:0] out_code,
    output logic      [2:0]  voltage_span,
    output logic             voltage_output_en,
    output logic             overrange_extend,
    output logic      [2:0]  current_span,
    output logic             current_output_en,
    output logic             modem_coupling_en
);
    // =====================================================
    // pin synchronisers
    logic [1:0] clr_sync_q;
    logic [1:0] sel_sync_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clr_sync_q <= 2'h0;
            sel_sync_q <= 2'h0;
        end else begin
            clr_sync_q <= {clr_sync_q[0], clear_input};
            sel_sync_q <= {sel_sync_q[0], clear_level_select};
        end
    end
    logic clr_pin;
    logic sel_pin;
    assign clr_pin = clr_sync_q[1];
    assign sel_pin = sel_sync_q[1];

    // =====================================================
    // register file
    logic [2:0]  range_q, range_d;
    logic        ovr_q, ovr_d;
    logic        slew_en_q, slew_en_d;
    logic [2:0]  step_sel_q, step_sel_d;
    logic [3:0]  rate_sel_q, rate_sel_d;
    logic        clrsel_bit_q, clrsel_bit_d;
    logic [1:0]  ispan_q, ispan_d;
    logic        dual_q, dual_d;
    logic [15:0] target_q, target_d;
    logic [15:0] code_q, code_d;
    logic [15:0] rdata_q, rdata_d;
    logic        active_q, active_d;
    slew_state_type state_q, state_d;
    logic        tick;
    logic        range_chg;
    logic [15:0] clear_code;
    logic [15:0] step;
    logic [2:0]  wr_range;

    // clear level: zero or mid scale; bipolar zero-scale is mid code
    function automatic logic [15:0] level_code(input logic [2:0] rng, input logic mid);
        logic bip;
        bip = (rng == SPAN_V_PM5) || (rng == SPAN_V_PM10);
        level_code = (mid || bip) ? 16'h8000 : 16'h0000;
    endfunction : level_code

    assign wr_range  = wdata[`CTL_RANGE_LSB +: 3];
    assign range_chg = wr && (addr == `REG_CONTROL_ADDR) && (wr_range != `RANGE_FORBIDDEN)
                       && (wr_range != range_q);
    assign clear_code = level_code(wr_range, sel_pin | wdata[`CTL_CLRSEL_BIT]);

    // control and config writes
    always_comb begin
        range_d      = range_q;
        ovr_d        = ovr_q;
        slew_en_d    = slew_en_q;
        step_sel_d   = step_sel_q;
        rate_sel_d   = rate_sel_q;
        clrsel_bit_d = clrsel_bit_q;
        ispan_d      = ispan_q;
        dual_d       = dual_q;
        if (wr && addr == `REG_CONTROL_ADDR) begin
            if (wr_range != `RANGE_FORBIDDEN) begin
                range_d = wr_range;
            end
            ovr_d        = wdata[`CTL_OVR_BIT];
            slew_en_d    = wdata[`CTL_SLEW_EN_BIT];
            step_sel_d   = wdata[`CTL_STEP_LSB +: 3];
            rate_sel_d   = wdata[`CTL_RATE_LSB +: 4];
            clrsel_bit_d = wdata[`CTL_CLRSEL_BIT];
        end
        if (wr && addr == `REG_CONFIG_ADDR) begin
            ispan_d = wdata[`CFG_ISPAN_LSB +: 2];
            dual_d  = wdata[`CFG_DUAL_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            range_q      <= `RANGE_RESET;
            ovr_q        <= 1'b0;
            slew_en_q    <= 1'b0;
            step_sel_q   <= 3'h0;
            rate_sel_q   <= 4'h0;
            clrsel_bit_q <= 1'b0;
            ispan_q      <= 2'h0;
            dual_q       <= 1'b0;
        end else begin
            range_q      <= range_d;
            ovr_q        <= ovr_d;
            slew_en_q    <= slew_en_d;
            step_sel_q   <= step_sel_d;
            rate_sel_q   <= rate_sel_d;
            clrsel_bit_q <= clrsel_bit_d;
            ispan_q      <= ispan_d;
            dual_q       <= dual_d;
        end
    end

    // =====================================================
    // slew engine
    // rate code to update tick
    slew_tick_gen #(
        .CLK_HZ   (CLK_HZ)
    ) u_tick (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .rate_sel (rate_sel_q),
        .tick     (tick)
    );

    assign step = 16'h0001 << step_sel_q;

    always_comb begin
        target_d = target_q;
        code_d   = code_q;
        state_d  = state_q;
        // target selection: range change, clear pin, data write
        if (range_chg) begin
            target_d = clear_code;
        end else if (clr_pin) begin
            target_d = level_code(range_q, 1'b0);
        end else if (wr && addr == `REG_DATA_ADDR) begin
            target_d = wdata;
        end
        case (state_q)
            SLEW_IDLE: begin
                if (!slew_en_q) begin
                    code_d = target_d;
                end else if (target_d != code_q) begin
                    state_d = SLEW_RUN;
                end
            end
            SLEW_RUN: begin
                if (!slew_en_q) begin
                    code_d  = target_d;
                    state_d = SLEW_IDLE;
                end else if (tick) begin
                    if (target_q > code_q) begin
                        code_d = (target_q - code_q <= step) ? target_q : code_q + step;
                    end else begin
                        code_d = (code_q - target_q <= step) ? target_q : code_q - step;
                    end
                end
                if (slew_en_q && code_d == target_d) begin
                    state_d = SLEW_IDLE;
                end
            end
            default: state_d = SLEW_IDLE;
        endcase
        active_d = (state_d == SLEW_RUN);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            target_q <= 16'h0000;
            code_q   <= 16'h0000;
            state_q  <= SLEW_IDLE;
            active_q <= 1'b0;
        end else begin
            target_q <= target_d;
            code_q   <= code_d;
            state_q  <= state_d;
            active_q <= active_d;
        end
    end

    // =====================================================
    // read port
    always_comb begin
        rdata_d = 16'h0000;
        if (rd) begin
            case (addr)
                `REG_STATUS_ADDR:  rdata_d[`STS_SLEW_ACTIVE_BIT] = active_q;
                `REG_DATA_ADDR:    rdata_d = code_q;
                `REG_CONTROL_ADDR: rdata_d = {3'h0, clrsel_bit_q, rate_sel_q, step_sel_q,
                                              slew_en_q, ovr_q, range_q};
                `REG_CONFIG_ADDR:  rdata_d = {13'h0, dual_q, ispan_q};
                default:           rdata_d = 16'h0000;
            endcase
        end
    end

    // =====================================================
    // range decode outputs
    logic [2:0] vspan_d, ispan_out_d;
    logic       ven_d, ien_d, modem_d;
    always_comb begin
        if (dual_q) begin
            ven_d       = ~range_q[2];
            vspan_d     = range_q[2] ? SPAN_NONE : range_q;
            ien_d       = (ispan_q != 2'h0);
            ispan_out_d = (ispan_q == 2'h0) ? SPAN_NONE : {1'b1, ispan_q};
        end else begin
            ven_d       = ~range_q[2];
            ien_d       = range_q[2];
            vspan_d     = range_q[2] ? SPAN_NONE : range_q;
            ispan_out_d = range_q[2] ? range_q : SPAN_NONE;
        end
        modem_d = (range_q == `RANGE_I_4_20);
    end

    logic [2:0] vspan_q, ispan_out_q;
    logic       ven_q, ien_q, modem_q, ovr_out_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q     <= 16'h0000;
            vspan_q     <= SPAN_NONE;
            ispan_out_q <= SPAN_NONE;
            ven_q       <= 1'b0;
            ien_q       <= 1'b0;
            modem_q     <= 1'b0;
            ovr_out_q   <= 1'b0;
        end else begin
            rdata_q     <= rdata_d;
            vspan_q     <= vspan_d;
            ispan_out_q <= ispan_out_d;
            ven_q       <= ven_d;
            ien_q       <= ien_d;
            modem_q     <= modem_d;
            ovr_out_q   <= ovr_q & ven_d;
        end
    end

    assign rdata             = rdata_q;
    assign out_code          = code_q;
    assign voltage_span      = vspan_q;
    assign voltage_output_en = ven_q;
    assign current_span      = ispan_out_q;
    assign current_output_en = ien_q;
    assign modem_coupling_en = modem_q;
    assign overrange_extend  = ovr_out_q;

    // =====================================================
    // checks
    // forbidden code
    range_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr && addr == `REG_CONTROL_ADDR && wr_range == `RANGE_FORBIDDEN) |=> range_q == $past(range_q))
        else $error("forbidden range code accepted");
    step_on_tick_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == SLEW_RUN && slew_en_q && !tick) |=> code_q == $past(code_q))
        else $error("step without tick");
    step_size_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == SLEW_RUN && slew_en_q && tick && target_q > code_q)
        |=> (code_q - $past(code_q)) <= (16'h0001 << $past(step_sel_q)))
        else $error("step too large");
    flag_state_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        active_q == (code_q != target_q))
        else $error("active flag wrong");
    data_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd && addr == `REG_DATA_ADDR) |=> rdata == $past(code_q))
        else $error("data read wrong");
    range_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        range_chg |=> target_q == $past(clear_code))
        else $error("range change did not clear");
    modem_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        modem_coupling_en |-> $past(range_q) == `RANGE_I_4_20)
        else $error("modem enabled outside 4-20");
    dual_voff_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (dual_q && range_q[2]) |=> !voltage_output_en)
        else $error("voltage not disabled");
endmodule : output_slew_range_control

// ===== slew_range_regs.svh
`ifndef SLEW_RANGE_REGS_SVH
`define SLEW_RANGE_REGS_SVH

// register offsets (word index on the plain port)
`define REG_STATUS_ADDR        4'h0
`define REG_DATA_ADDR          4'h1
`define REG_CONTROL_ADDR       4'h2
`define REG_CONFIG_ADDR        4'h3
// control register fields
`define CTL_RANGE_LSB          0
`define CTL_OVR_BIT            3
`define CTL_SLEW_EN_BIT        4
`define CTL_STEP_LSB           5
`define CTL_RATE_LSB           8
`define CTL_CLRSEL_BIT         12
// configuration register fields
`define CFG_ISPAN_LSB          0
`define CFG_DUAL_BIT           2
// status register fields
`define STS_SLEW_ACTIVE_BIT    1
// reset values and codes
`define RANGE_RESET            3'h0
`define RANGE_FORBIDDEN        3'h4
`define RANGE_I_4_20           3'h5
// system clock in Hz
`define SYS_CLK_HZ             40000000
// slew update frequencies per rate code, in Hz
`define SLEW_FREQ_HZ_LIST      258065, 200000, 153845, 131145, 115940, 69565, 37560, 25805, \
                               20150, 16030, 10295, 8280, 6900, 5530, 4240, 3300

`endif

// ===== slew_range_pkg.sv
package slew_range_pkg;
    typedef enum logic [1:0] {
        SLEW_IDLE = 2'b00,
        SLEW_RUN  = 2'b01
    } slew_state_type;

    typedef enum logic [2:0] {
        SPAN_V_0_5   = 3'b000,
        SPAN_V_0_10  = 3'b001,
        SPAN_V_PM5   = 3'b010,
        SPAN_V_PM10  = 3'b011,
        SPAN_NONE    = 3'b100,
        SPAN_I_4_20  = 3'b101,
        SPAN_I_0_20  = 3'b110,
        SPAN_I_0_24  = 3'b111
    } span_type;
endpackage : slew_range_pkg

// ===== slew_tick_gen.sv
`timescale 1ns/1ps
`include "slew_range_regs.svh"
// =====================================================
// update tick generator
module slew_tick_gen
    import slew_range_pkg::*;
#(
    parameter int CLK_HZ = `SYS_CLK_HZ
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [3:0] rate_sel,
    output logic            tick
);
    // update frequencies per rate code, in Hz
    localparam int FREQ_HZ [16] = '{`SLEW_FREQ_HZ_LIST};

    logic [15:0] div_tab [16];
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        tick_q;
    logic        tick_d;

    // cycles per update period, rounded down to the nearest whole cycle
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_div
            assign div_tab[g] = 16'(CLK_HZ / FREQ_HZ[g]);
        end
    endgenerate

    always_comb begin
        cnt_d  = cnt_q + 16'h0001;
        tick_d = 1'b0;
        if (cnt_q >= div_tab[rate_sel] - 16'h0001) begin
            cnt_d  = 16'h0000;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule : slew_tick_gen

// ===== output_slew_range_control_tb.sv
`timescale 1ns/1ps
`include "slew_range_regs.svh"
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin errors++; \
    $display("unexpected %s: expected %h seen %h", nm, e, s); end end

// =====================================================
// bench top
module output_slew_range_control_tb;
    localparam int CLK_HZ_TB   = 4000000;
    localparam int FREQ_TBL[16] = '{258065, 200000, 153845, 131145, 115940, 69565, 37560, 25805,
                                    20150, 16030, 10295, 8280, 6900, 5530, 4240, 3300};
    logic        clk_sys, rst_n, wr, rd, clear_input, clear_level_select;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, out_code;
    logic [2:0]  voltage_span, current_span;
    logic        voltage_output_en, overrange_extend, current_output_en, modem_coupling_en;
    // bench state: expected register contents and notes of pending reads
    logic [2:0]  rng;
    logic        dual;
    logic [1:0]  ispan;
    logic [15:0] ctl_exp, model, lfsr;
    logic [31:0] note;
    logic        rd_seen = 1'b0;
    logic [31:0] exp_q[$];
    int          step, errors = 0, num_checks = 0;

    output_slew_range_control #(.CLK_HZ(CLK_HZ_TB)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .clear_input(clear_input), .clear_level_select(clear_level_select),
        .out_code(out_code), .voltage_span(voltage_span), .voltage_output_en(voltage_output_en),
        .overrange_extend(overrange_extend), .current_span(current_span),
        .current_output_en(current_output_en), .modem_coupling_en(modem_coupling_en));

    // 40 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // compare each read answer with the oldest note
    always @(posedge clk_sys) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("unexpected rdata: expected none seen %h", rdata);
            end else begin
                note = exp_q.pop_front();
                `CHK("rdata", note[15:0], rdata & note[31:16]) // read answers
            end
        end
        rd_seen <= rd;
    end

    // =====================================================
    // bus tasks
    task automatic drive(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
    endtask : drive

    task automatic idle(input int n);
        repeat (n) drive(1'b0, 1'b0, addr, wdata);
    endtask : idle

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        drive(1'b1, 1'b0, a, d);
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        exp_q.push_back({m, e & m});
        drive(1'b0, 1'b1, a, 16'h0);
    endtask : rd_reg

    // control write; a real range change clears the data to the clear level
    task automatic ctl(input logic [15:0] v);
        drive(1'b1, 1'b0, `REG_CONTROL_ADDR, v);
        if (v[2:0] != 3'h4 && v[2:0] != rng) begin
            rng = v[2:0];
            model = (v[12] | clear_level_select | (rng[2:1] == 2'b01)) ? 16'h8000 : 16'h0;
        end
        ctl_exp = {v[15:3], rng};
    endtask : ctl

    // span and enable outputs against the bench copy of range settings
    task automatic chk_out();
        logic [2:0] vs, cs;
        vs = rng[2] ? 3'h4 : rng;
        cs = dual ? ((ispan == 2'h0) ? 3'h4 : {1'b1, ispan}) : (rng[2] ? rng : 3'h4);
        `CHK("voltage_span", vs, voltage_span) // voltage span
        `CHK("voltage_output_en", !rng[2], voltage_output_en) // voltage enable
        `CHK("current_span", cs, current_span) // current span
        `CHK("current_output_en", (cs != 3'h4), current_output_en) // current enable
        `CHK("overrange_extend", (ctl_exp[3] & !rng[2]), overrange_extend) // widened span
        `CHK("modem_coupling_en", (rng == 3'h5), modem_coupling_en) // coupling gate
    endtask : chk_out

    // follow the staircase to tgt, checking each step, and the period of every step after the first
    task automatic follow(input logic [15:0] tgt, input int per);
        logic [15:0] prev;
        int n, k;
        k = 0;
        while (model !== tgt) begin
            prev = model;
            if (tgt > model) model = (tgt - model > step) ? model + 16'(step) : tgt;
            else model = (model - tgt > step) ? model - 16'(step) : tgt;
            for (n = (k > 0); out_code === prev && n <= 2 * per + 8; n++) idle(1);
            if (n > 2 * per + 8) begin
                errors++;
                $display("unexpected wait: out_code never moved");
                complete_run();
            end
            `CHK("out_code", model, out_code) // clamped step size
            if (k > 0) `CHK("step period", per, n) // update period
            rd_reg(`REG_DATA_ADDR, model, 16'hffff); // stepped value
            k++;
        end
    endtask : follow

    task automatic slew_to(input logic [15:0] tgt, input int rate);
        wr_reg(`REG_DATA_ADDR, tgt);
        rd_reg(`REG_STATUS_ADDR, 16'h0002, 16'h0002); // busy flag
        follow(tgt, CLK_HZ_TB / FREQ_TBL[rate]);
        rd_reg(`REG_STATUS_ADDR, 16'h0000, 16'h0002); // flag clear
    endtask : slew_to

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    task automatic complete_run();
        $display("checks made %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run

    // =====================================================
    // main sequence
    initial begin
        rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 16'h0;
        clear_input = 1'b0; clear_level_select = 1'b0;
        rng = 3'h0; dual = 1'b0; ispan = 2'h0; ctl_exp = 16'h0; model = 16'h0; step = 1;
        lfsr = 16'h0046;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd_reg(`REG_STATUS_ADDR, 16'h0, 16'hffff); // idle status
        rd_reg(`REG_CONTROL_ADDR, 16'h0, 16'h1fff); // control layout
        rd_reg(4'h7, 16'h0, 16'hffff); // unmapped place
        idle(2);
        chk_out();
        $display("test reset done");
        // random data with slew off lands at once
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            wr_reg(`REG_DATA_ADDR, lfsr);
            model = lfsr;
            rd_reg(`REG_DATA_ADDR, lfsr, 16'hffff); // direct update
        end
        $display("test direct data done");
        // every range code, overrange on odd codes, mid level by bit on code 1, by pin on the top two
        for (int r = 0; r < 8; r++) begin
            clear_level_select <= (r > 5);
            wr_reg(`REG_DATA_ADDR, 16'h5a5a);
            model = 16'h5a5a;
            idle(2);
            ctl({3'h0, (r == 1), 8'h0, r[0], r[2:0]}); // mid level by control bit
            idle(2);
            chk_out();
            rd_reg(`REG_CONTROL_ADDR, ctl_exp, 16'h1fff); // code 100 refused
            rd_reg(`REG_DATA_ADDR, model, 16'hffff); // clear on change
        end
        clear_level_select <= 1'b0;
        $display("test ranges done");
        // dual output mode, every current span code
        dual = 1'b1;
        for (int c = 0; c < 4; c++) begin
            ispan = c[1:0];
            wr_reg(`REG_CONFIG_ADDR, {13'h0, 1'b1, ispan});
            idle(2);
            chk_out();
            rd_reg(`REG_CONFIG_ADDR, {13'h0, 1'b1, ispan}, 16'h0007); // dual fields
        end
        ctl(16'h000a);
        idle(2);
        chk_out();
        dual = 1'b0;
        ispan = 2'h0;
        wr_reg(`REG_CONFIG_ADDR, 16'h0);
        ctl(16'h0000);
        idle(2);
        $display("test dual mode done");
        // settings first, then data: every step size at the fastest rate
        for (int s = 0; s < 8; s++) begin
            step = 1 << s;
            ctl({8'h0, s[2:0], 5'h10}); // settings before data
            slew_to(model + 16'(2 * step + 1), 0);
        end
        $display("test step sizes done");
        // every update rate
        step = 1;
        for (int t = 0; t < 16; t++) begin
            ctl({4'h0, t[3:0], 8'h10});
            slew_to(model + 16'h3, t);
        end
        // same rate in a current range
        ctl(16'h0006);
        ctl(16'h0c16);
        slew_to(model + 16'h3, 12);
        $display("test update rates done");
        // clear pin ramps down to zero-scale
        step = 8;
        ctl(16'h0076);
        slew_to(16'h0040, 0);
        clear_input <= 1'b1;
        follow(16'h0000, CLK_HZ_TB / FREQ_TBL[0]); // ramp to zero
        clear_input <= 1'b0;
        rd_reg(`REG_STATUS_ADDR, 16'h0000, 16'h0002); // flag clear
        idle(3);
        $display("test clear ramp done");
        complete_run();
    end
endmodule : output_slew_range_control_tb
